// ### design/swr_top.sv
// Supervisor top: power-fail, pushbutton and watchdog reset generation.
`timescale 1ns/1ps

// Summary of operation
// - Power fault forces both reset outputs active.
// - After power returns, hold reset at least 250 ms before release.
// - Assert reset within 175 us of power failure.
// - Pushbutton input is active low and debounced internally.
// - Pushbutton hold interval starts once the debouncer accepts the release, PB_DEB_TK ticks after the button is released.
// - Assert reset within 20 ms of pushbutton being stably low.
// - Timeout select picks 150 ms, 600 ms or 1.2 s.
// - Watchdog starts a full period when reset goes inactive.
// - Each strobe falling edge restarts a full watchdog period.
// - Watchdog expiry drives reset active for at least 250 ms.
// - Watchdog cannot be disabled; armed whenever reset is inactive.
// - Two reset outputs, high and low active, identical timing.
// - Active-low reset is open drain: pull low or release.
module swr_top
	import swr_pkg::*;
#(
	parameter int TICK_CYC   = TICK_CYCLES,
	parameter int HOLD_TK    = HOLD_TICKS,
	parameter int PB_DEB_TK  = PB_DEB_TICKS,
	parameter int WD_SHORT   = WD_SHORT_TICKS,
	parameter int WD_MID     = WD_MID_TICKS,
	parameter int WD_LONG    = WD_LONG_TICKS
)
(
	input  wire logic       CLK_SYS,
	input  wire logic       NRST,
	input  wire logic       POWER_GOOD,
	input  wire logic       PUSHBUTTON_RESET_N,
	input  wire logic       WATCHDOG_STROBE_N,
	input  wire logic [1:0] TIMEOUT_SELECT,
	output logic            RESET,
	output logic            RESET_N_O,
	output logic            RESET_N_OE
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	initial
	begin
		if (TICK_CYC < 1 || HOLD_TK < 1 || PB_DEB_TK < 1)
			$error("swr_top: tick, hold and debounce counts must be positive.");
		if (WD_SHORT < 1 || WD_MID < WD_SHORT || WD_LONG < WD_MID)
			$error("swr_top: watchdog periods must be positive and ordered.");
	end

	typedef struct packed
	{
		swr_state_t  state;
		logic [31:0] tick_cnt;
		logic        tick;
		logic [31:0] hold_cnt;
		logic [31:0] wd_cnt;
		logic        strobe_q;
		logic        reset;
		logic        reset_n_oe;
	} swr_top_t;

	swr_top_t st;
	swr_top_t next_st;
	logic     pb_pressed;
	logic     pf;
	logic     strobe_fall;
	logic     wd_expired;
	logic     any_req;
	logic [31:0] wd_period;

	// ----------------------------------------------------------------
	// Pushbutton debouncer on the shared time base.
	// ----------------------------------------------------------------
	swr_debounce #(
		.STABLE_TICKS (PB_DEB_TK)
	) u_debounce (
		.clk     (CLK_SYS),
		.rst_n   (NRST),
		.tick    (st.tick),
		.raw_n   (PUSHBUTTON_RESET_N),
		.pressed (pb_pressed)
	);

	// Timeout decode; an undefined code takes the longest period as the safe choice.
	always_comb
	begin
		case (TIMEOUT_SELECT)
			TSEL_GND:   wd_period = 32'(WD_SHORT);
			TSEL_FLOAT: wd_period = 32'(WD_MID);
			TSEL_HIGH:  wd_period = 32'(WD_LONG);
			default:    wd_period = 32'(WD_LONG);
		endcase
	end

	// Request terms feeding the single hold timer.
	assign pf          = !POWER_GOOD;
	assign strobe_fall = st.strobe_q && !WATCHDOG_STROBE_N;
	assign wd_expired  = (st.state == SWR_RUN) && st.tick && !strobe_fall
	                     && (st.wd_cnt <= 32'h0000_0001);
	assign any_req     = pf || pb_pressed;

	// ----------------------------------------------------------------
	// Next-state logic: time base, hold timer and watchdog.
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st          = st;
		next_st.strobe_q = WATCHDOG_STROBE_N;
		// One divider for every interval in the block.
		next_st.tick     = 1'b0;
		if (st.tick_cnt >= 32'(TICK_CYC - 1))
		begin
			next_st.tick_cnt = 32'h0000_0000;
			next_st.tick     = 1'b1;
		end
		else
			next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;

		case (st.state)
			SWR_RUN:
			begin
				if (any_req || wd_expired)
				begin
					// Reset drops in the cycle after the request, far inside 175 us.
					next_st.state    = SWR_HOLD;
					next_st.hold_cnt = 32'(HOLD_TK);
					next_st.wd_cnt   = 32'h0000_0000;
				end
				else if (strobe_fall)
					next_st.wd_cnt = wd_period;
				else if (st.tick)
					next_st.wd_cnt = st.wd_cnt - 32'h0000_0001;
			end
			SWR_HOLD:
			begin
				next_st.wd_cnt = 32'h0000_0000;
				if (any_req)
					next_st.hold_cnt = 32'(HOLD_TK);
				else if (st.hold_cnt <= 32'h0000_0001 && st.tick)
				begin
					next_st.state  = SWR_RUN;
					next_st.wd_cnt = wd_period;
				end
				else if (st.tick)
					next_st.hold_cnt = st.hold_cnt - 32'h0000_0001;
			end
			default:
				next_st.state = SWR_HOLD;
		endcase

		next_st.reset      = (next_st.state == SWR_HOLD);
		next_st.reset_n_oe = (next_st.state == SWR_HOLD);
	end

	// ----------------------------------------------------------------
	// State register; reset starts in hold, as at power-up.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS)
	begin
		if (!NRST)
		begin
			st            <= '0;
			st.state      <= SWR_HOLD;
			st.hold_cnt   <= 32'(HOLD_TK);
			st.strobe_q   <= 1'b1;
			st.reset      <= 1'b1;
			st.reset_n_oe <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Outputs straight from flops; open-drain level is always low when driven.
	assign RESET      = st.reset;
	assign RESET_N_OE = st.reset_n_oe;
	assign RESET_N_O  = 1'b0;

endmodule

// ### design/swr_pkg.sv
// Package with timing constants and encodings for the supervisor watchdog reset block.
package swr_pkg;

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 5;
	localparam int CLK_PER_US      = 1000 / CLK_PERIOD_NS;
	// One tick of the shared time base is 1 us.
	localparam int TICK_US         = 1;
	localparam int TICK_CYCLES     = TICK_US * CLK_PER_US;

	// ----------------------------------------------------------------
	// Intervals in their own units, as figures, then in ticks (power-fail limit in clock cycles)
	// ----------------------------------------------------------------
	localparam int HOLD_MS         = 250;
	localparam int HOLD_TICKS      = HOLD_MS * 1000 / TICK_US;
	localparam int PF_DETECT_US    = 175;
	localparam int PF_DETECT_CYC   = PF_DETECT_US * CLK_PER_US;
	localparam int PB_STABLE_MS    = 20;
	// Debounce is half the assert limit so that assertion lands well inside it.
	localparam int PB_DEB_TICKS    = PB_STABLE_MS * 1000 / TICK_US / 2;
	localparam int WD_SHORT_MS     = 150;
	localparam int WD_MID_MS       = 600;
	localparam int WD_LONG_MS      = 1200;
	localparam int WD_SHORT_TICKS  = WD_SHORT_MS * 1000 / TICK_US;
	localparam int WD_MID_TICKS    = WD_MID_MS * 1000 / TICK_US;
	localparam int WD_LONG_TICKS   = WD_LONG_MS * 1000 / TICK_US;

	// ----------------------------------------------------------------
	// Three-state timeout select encoding
	// ----------------------------------------------------------------
	localparam logic [1:0] TSEL_GND   = 2'h0;
	localparam logic [1:0] TSEL_FLOAT = 2'h1;
	localparam logic [1:0] TSEL_HIGH  = 2'h2;

	typedef enum logic [0:0]
	{
		SWR_RUN  = 1'b0,
		SWR_HOLD = 1'b1
	} swr_state_t;

endpackage

// ### design/swr_debounce.sv
// Debouncer for the active-low pushbutton input.
`timescale 1ns/1ps

module swr_debounce
	import swr_pkg::*;
#(
	parameter int STABLE_TICKS = PB_DEB_TICKS
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic tick,
	input  wire logic raw_n,
	output logic      pressed
);

	initial
	begin
		if (STABLE_TICKS < 1)
			$error("swr_debounce: STABLE_TICKS must be at least one.");
	end

	typedef struct packed
	{
		logic [31:0] cnt;
		logic        pressed;
	} swr_deb_t;

	swr_deb_t st;
	swr_deb_t next_st;

	// ----------------------------------------------------------------
	// Change of level is accepted only after it held for STABLE_TICKS.
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		if ((!raw_n) == st.pressed)
			next_st.cnt = 32'h0000_0000; // Input agrees; restart the stability window.
		else if (tick)
		begin
			if (st.cnt >= 32'(STABLE_TICKS - 1))
			begin
				next_st.pressed = !raw_n;
				next_st.cnt     = 32'h0000_0000;
			end
			else
				next_st.cnt = st.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign pressed = st.pressed;

endmodule

// ### tb/swr_proc_model.sv
// Model of the supervised processor that strobes the watchdog.
`timescale 1ns/1ps
module swr_proc_model
(
	input  wire logic       clk,
	input  wire logic       rst_line_n,
	input  wire logic       run,
	input  wire logic [7:0] gap,
	output logic            strobe_n
);
	int n = 0;
	initial strobe_n = 1'b1;
	// One low cycle every gap + 1 cycles; a held processor stays silent.
	always @(posedge clk)
	begin
		n <= (!rst_line_n || !run || n >= gap) ? 0 : n + 1;
		strobe_n <= #1 !(run && rst_line_n && n == gap);
	end
endmodule

// ### tb/swr_top_chk.sv
// Checker of the reset outputs of the supervisor block.
`timescale 1ns/1ps
module swr_top_chk
#(
	parameter int HOLD_TK  = 20,
	parameter int WD_SHORT = 30,
	parameter int WD_MID   = 60,
	parameter int WD_LONG  = 120
)
(
	input wire logic       CLK_SYS,
	input wire logic       NRST,
	input wire logic       POWER_GOOD,
	input wire logic       PUSHBUTTON_RESET_N,
	input wire logic       WATCHDOG_STROBE_N,
	input wire logic [1:0] TIMEOUT_SELECT,
	input wire logic       RESET,
	input wire logic       RESET_N_O,
	input wire logic       RESET_N_OE
);
	int wd;
	int per;
	int hi;
	int pg_ok;
	int pb_up;
	// Runs of consecutive samples; a long hold is judged on a counter, not a long repetition.
	always_ff @(posedge CLK_SYS)
	begin
		hi    <= RESET ? hi + 1 : 0;
		pg_ok <= POWER_GOOD ? pg_ok + 1 : 0;
		pb_up <= PUSHBUTTON_RESET_N ? pb_up + 1 : 0;
	end
	// Cycles since the last strobe fall; one spare cycle covers the reload.
	assign per = TIMEOUT_SELECT == 2'h0 ? WD_SHORT : TIMEOUT_SELECT == 2'h1 ? WD_MID : WD_LONG;
	always_ff @(posedge CLK_SYS)
		wd <= (!NRST || RESET || $fell(WATCHDOG_STROBE_N)) ? 0 : wd + 1;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	AST_PF_SET: assert property (!POWER_GOOD |=> RESET) else $error("late power reset");
	AST_PF_HOLD: assert property ($fell(RESET) |-> pg_ok >= HOLD_TK)
		else $error("power hold short");
	AST_PB_SET: assert property (!PUSHBUTTON_RESET_N [*8] |-> RESET)
		else $error("late button reset");
	AST_PB_HOLD: assert property ($fell(RESET) |-> pb_up >= HOLD_TK)
		else $error("button hold short");
	AST_WD_BOUND: assert property (!RESET |-> wd <= per + 1)
		else $error("watchdog overran");
	AST_HOLD_MIN: assert property ($fell(RESET) |-> hi >= HOLD_TK)
		else $error("reset pulse short");
	AST_TWIN: assert property (RESET_N_OE == RESET) else $error("outputs differ");
	AST_OD_LOW: assert property (RESET_N_O == 1'b0) else $error("drain not low");
	C_PF: cover property (!POWER_GOOD);
	C_WD: cover property ($rose(RESET) && POWER_GOOD && PUSHBUTTON_RESET_N);
	C_ST: cover property ($fell(WATCHDOG_STROBE_N) && !RESET);
endmodule
bind swr_top swr_top_chk #(.HOLD_TK(HOLD_TK), .WD_SHORT(WD_SHORT), .WD_MID(WD_MID),
	.WD_LONG(WD_LONG)) chk_u (.*);

// ### tb/supervisor_watchdog_reset_test.sv
// Self-checking bench of the supervisor block.
`timescale 1ns/1ps
module supervisor_watchdog_reset_test;
	localparam int HOLD = 20;
	localparam int DEB = 3;
	localparam int WDP [4] = '{30, 60, 120, 120};
	logic clk = 0, nrst = 0, pg = 0, pb_n = 1, run = 0;
	logic [1:0] tsel = 2'h0;
	logic [7:0] gap = 8'h0a;
	logic rst, rst_n_o, rst_n_oe, st_n;
	wire rst_line_n = rst_n_oe ? rst_n_o : 1'b1; // Pull-up when released.
	int fails = 0, cmp_count = 0, n;
	swr_top #(.TICK_CYC(1), .HOLD_TK(HOLD), .PB_DEB_TK(DEB), .WD_SHORT(30), .WD_MID(60),
		.WD_LONG(120)) dut_u (.CLK_SYS(clk), .NRST(nrst), .POWER_GOOD(pg),
		.PUSHBUTTON_RESET_N(pb_n), .WATCHDOG_STROBE_N(st_n), .TIMEOUT_SELECT(tsel),
		.RESET(rst), .RESET_N_O(rst_n_o), .RESET_N_OE(rst_n_oe));
	swr_proc_model proc_u (.clk(clk), .rst_line_n(rst_line_n), .run(run), .gap(gap),
		.strobe_n(st_n));
	// Clock of 5 ns.
	initial forever #2.5 clk = ~clk;
	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic cyc(input int k); repeat (k) @(posedge clk); #1; endtask
	task automatic chk(input logic got, input logic exp, input string m);
		cmp_count++;
		if (got !== exp) begin fails++; $display("wrong value at %0t: %s", $time, m); end
	endtask
	task automatic win(input int lo, input int hi, input string m);
		chk(n >= lo && n <= hi, 1'b1, m);
	endtask
	// Bounded wait; a hang ends the run with a mismatch.
	task automatic wait_rst(input logic v);
		n = 0;
		while (rst !== v && n < 2000) begin cyc(1); n++; end
		if (n >= 2000) begin chk(1'b0, 1'b1, "timeout"); give_verdict(); end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic s_powerup;
		cyc(8); nrst = 1; pg = 1; cyc(2);
		chk(rst, 1'b1, "hold"); chk(rst_line_n, 1'b0, "line");
		wait_rst(0); win(HOLD - 2, HOLD + 2, "power-up hold");
		chk(rst_line_n, 1'b1, "line free");
	endtask
	task automatic s_watchdog;
		for (int t = 0; t < 4; t++) begin
			wait_rst(1); win(WDP[t] - 2, WDP[t] + 2, "timeout");
			tsel = 2'(t + 1);
			wait_rst(0); win(HOLD - 2, HOLD + 2, "wd hold");
		end
	endtask
	task automatic s_strobe;
		run = 1;
		repeat (200) begin cyc(1); chk(rst, 1'b0, "strobed"); end
	endtask
	task automatic s_powerfail;
		pg = 0; cyc(2); chk(rst, 1'b1, "pf set");
		cyc(40); chk(rst, 1'b1, "pf held");
		pg = 1; wait_rst(0); win(HOLD - 2, HOLD + 2, "pf hold");
	endtask
	task automatic s_button;
		pb_n = 0; cyc(2); pb_n = 1; cyc(10); chk(rst, 1'b0, "glitch");
		pb_n = 0; wait_rst(1); win(DEB, DEB + 3, "pb set");
		cyc(30); pb_n = 1;
		wait_rst(0); win(HOLD + DEB - 1, HOLD + DEB + 3, "pb hold");
	endtask
	// A second reset in mid-run must restart the full hold, as at power-up.
	task automatic s_rearm;
		nrst = 0; cyc(2); chk(rst, 1'b1, "rearm set");
		nrst = 1; wait_rst(0); win(HOLD - 2, HOLD + 2, "rearm hold");
		cyc(100); chk(rst, 1'b0, "rearm strobed");
	endtask
	// Main sequence.
	initial
	begin
		s_powerup(); s_watchdog(); s_strobe(); s_powerfail(); s_button(); s_rearm();
		give_verdict();
	end
endmodule
